// *** bench/fpdrc_host_model.sv ***
// Host model driving serial frames onto the flash pins
`timescale 1ns/10ps
module fpdrc_host_model (
	// Clock
	input  wire logic i_clk,
	// Serial pins
	output logic      o_sck,
	output logic      o_cs_n,
	output logic      o_si
);
	// Idle pins: clock stands low, chip select high
	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_si = 1'b0;
	end
	// Frame of n clocks, opcode MSB first, SI at lvl when selected
	task automatic send(input logic [7:0] op, input int n, input logic lvl);
		o_si <= lvl;
		@(posedge i_clk);
		o_cs_n <= 1'b0;
		repeat (4) @(posedge i_clk);
		for (int i = 0; i < n; i++) begin
			o_si <= op[7-i];
			repeat (4) @(posedge i_clk);
			o_sck <= 1'b1;
			repeat (4) @(posedge i_clk);
			o_sck <= 1'b0;
		end
		repeat (4) @(posedge i_clk);
		o_cs_n <= 1'b1;
		o_si <= ~o_si; // Released line keeps no stale level
		repeat (8) @(posedge i_clk);
	endtask
endmodule

// *** bench/fpdrc_monitor.sv ***
// Port assertions for the power-down control
`timescale 1ns/10ps
module fpdrc_monitor (
	// Clock and reset
	input wire logic                     i_clk,
	input wire logic                     i_arst_n,
	// Watched outputs
	input wire logic                     o_so_oe_n,
	input wire fpdrc_pkg::fpdrc_status_t o_status,
	input wire logic                     o_ready,
	input wire logic                     o_dev_reset,
	input wire logic                     o_op_halt
);
	import fpdrc_pkg::*;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	// Short names for status fields
	wire logic lt = o_status.light_sleep;
	wire logic dp = o_status.deepest_sleep;
	wire logic rc = o_status.recovering;
	wire logic bz = o_status.op_busy;
	wire logic er = o_status.prog_error | o_status.erase_error;
	// Sleep keeps the output released and the device not ready
	sleep_oe_a: assert property ((lt | dp) |-> o_so_oe_n)
		else $error("output driven asleep");
	sleep_ready_a: assert property ((lt | dp) |-> !o_ready)
		else $error("ready while asleep");
	// Exits pass through recovery
	light_exit_a: assert property ($fell(lt) |-> rc && !dp)
		else $error("light exit bad");
	deep_exit_a: assert property ($fell(dp) |-> rc && o_dev_reset)
		else $error("deep exit bad");
	rec_hold_a: assert property ($rose(rc) |-> (rc && !o_ready) [*8])
		else $error("recovery too short");
	// Terminate stops the operation without a reset
	// Status fields trail the event pulses by one clock
	halt_stop_a: assert property (o_op_halt |-> bz ##1 (!bz && er))
		else $error("halt did not stop");
	halt_keep_a: assert property (o_op_halt |-> !o_dev_reset && !rc)
		else $error("halt reset device");
	reset_clear_a: assert property (o_dev_reset |=> !bz && !er)
		else $error("reset left state");
endmodule
bind fpdrc_top fpdrc_monitor i_mon (.i_clk, .i_arst_n, .o_so_oe_n,
	.o_status, .o_ready, .o_dev_reset, .o_op_halt);

// *** bench/testbench.sv ***
// Self-checking bench for the power-down control
`timescale 1ns/10ps
module testbench;
	import fpdrc_pkg::*;
	logic          clk, arst_n, pin_n, en, done, perr, eerr;
	logic          sck, cs_n, si, so, oe_n, ready, rst, halt;
	logic [7:0]    sr4, op;
	fpdrc_status_t st;
	int            seed = 62;
	int            n_mismatch = 0;
	int            cmp_count = 0;
	int            n_rst, n_halt, n_rec;
	logic [7:0]    cls [11] = '{OP_PG_BYTE, OP_PG_SEQ_A, OP_PG_SEQ_B,
		OP_PG_DUAL, OP_PG_QUAD, OP_PG_OTP, OP_ER_4K, OP_ER_32K,
		OP_ER_64K, OP_ER_CHIP_A, OP_ER_CHIP_B};
	// Design and host
	fpdrc_top i_dut (.i_clk(clk), .i_arst_n(arst_n),
		.i_pins({sck, cs_n, si, pin_n}), .i_fourth_status_register(sr4),
		.i_hw_reset_enable(en), .i_op_done(done), .i_prog_err_set(perr),
		.i_erase_err_set(eerr), .o_so(so), .o_so_oe_n(oe_n),
		.o_status(st), .o_ready(ready), .o_dev_reset(rst),
		.o_op_halt(halt));
	fpdrc_host_model i_host (.i_clk(clk), .o_sck(sck), .o_cs_n(cs_n),
		.o_si(si));
	// Clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Event counters
	always @(posedge clk) begin
		n_rst += (rst === 1'b1);
		n_halt += (halt === 1'b1);
		n_rec += (st.recovering === 1'b1);
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t: got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic [7:0] c);
		i_host.send(c, 8, 1'b0);
	endtask
	// Exit by pin (00), serial reset (01) or command, then wait
	task automatic go(input logic [7:0] c, input int cyc);
		n_rec = 0;
		n_rst = 0;
		if (c == 8'h00) begin
			pin_n <= 1'b0;
			repeat (8) @(posedge clk);
			pin_n <= 1'b1;
		end else if (c == 8'h01) begin
			for (int i = 0; i < 4; i++) i_host.send(8'h00, 0, i[0]);
		end else cmd(c);
		for (int i = 0; i < 4000 && ready !== 1'b1; i++) @(posedge clk);
		check(n_rec, cyc);
	endtask
	task automatic final_report;
		$display("Compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		{arst_n, done, perr, eerr} = 4'h0;
		pin_n = 1'b1;
		en = 1'b1;
		sr4 = 8'h80;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		repeat (5) @(posedge clk);
		check({ready, oe_n, st}, 8'hc0);
		perr <= 1'b1;
		@(posedge clk);
		perr <= 1'b0;
		cmd(OP_SLEEP);
		check({st.light_sleep, st.deepest_sleep, ready}, 3'h4);
		cmd(OP_TERMINATE);
		check(st.light_sleep, 1'b1);
		for (int i = 0; i < 3; i++) begin
			op = 8'($random(seed));
			if (op inside {OP_RESUME, OP_RST_EN, OP_RST_DO}) op = 8'h05;
			cmd(op);
		end
		check({st.light_sleep, cs_n, oe_n, so}, 4'he);
		go(OP_RESUME, LIGHT_EXIT_CYC_I + 1);
		check({n_rst[0], st.prog_error}, 2'h1);
		sr4 <= 8'h7f;
		cmd(OP_SLEEP);
		check({st.light_sleep, st.deepest_sleep}, 2'h1);
		cmd(OP_RST_EN);
		cmd(OP_RST_DO);
		check(st.deepest_sleep, 1'b1);
		go(OP_RESUME, DEEP_EXIT_CYC_I + 1);
		check({n_rst[0], st.prog_error}, 2'h2);
		sr4 <= 8'h80;
		cmd(OP_DEEP);
		check(st.deepest_sleep, 1'b1);
		go(8'h01, DEEP_EXIT_CYC_I + 1);
		check(n_rst, 1);
		cmd(OP_SLEEP);
		go(8'h00, LIGHT_EXIT_CYC_I + 1);
		cmd(OP_SLEEP);
		cmd(OP_RST_EN);
		go(OP_RST_DO, LIGHT_EXIT_CYC_I + 1);
		cmd(OP_SLEEP);
		arst_n <= 1'b0;
		@(posedge clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge clk);
		check({ready, st}, 7'h40);
		foreach (cls[i]) begin
			cmd(cls[i]);
			check(st.op_busy, 1'b1);
			n_halt = 0;
			cmd(OP_TERMINATE);
			check({n_halt[1:0], st.op_busy, st.prog_error, st.erase_error},
				{4'h5, i > 5});
		end
		cmd(OP_ER_4K);
		eerr <= 1'b1;
		@(posedge clk);
		eerr <= 1'b0;
		cmd(OP_RST_EN);
		n_rst = 0;
		cmd(OP_RST_DO);
		check({n_rst[1:0], st.op_busy, st.erase_error, st.prog_error},
			5'h08);
		cmd(OP_PG_QUAD);
		done <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
		repeat (2) @(posedge clk);
		check(st.op_busy, 1'b0);
		final_report;
	end
	// Watchdog
	initial begin
		#4000000;
		n_mismatch++;
		final_report;
	end
endmodule

// *** logic/fpdrc_pkg.sv ***
// Package of constants and types for the flash power-down and reset control
// Notes on behaviour
// R1: B9h with select bit set enters light sleep
// R2: B9h with select bit clear enters deepest sleep
// R3: 79h always enters deepest sleep
// R4: Select bit is fourth status register bit 7
// R5: ABh leaves light sleep, keeps SRAM and data
// R6: ABh leaves deepest sleep through internal reset
// R7: 66h then 99h leaves light sleep
// R8: 66h/99h never leaves deepest sleep
// R9: F0h never leaves any sleep state
// R10: Chip select rise alone keeps sleep
// R11: Power-on, serial or pin reset wakes both
// R12: Host enables reset pin before sleeping
// R13: Light exit short, deepest exit long recovery
// R14: Any reset aborts program/erase and resets device
// R15: F0h halts program/erase without device reset
// R16: Program class is 02h AFh ADh A2h 32h 9Bh
// R17: Erase class is 20h 52h D8h 60h C7h
// R18: Light wake keeps error flags, deepest clears
// R19: Asleep: ignore other commands, output undriven
package fpdrc_pkg;

	// Opcodes
	localparam logic [7:0] OP_SLEEP     = 8'hb9;
	localparam logic [7:0] OP_DEEP      = 8'h79;
	localparam logic [7:0] OP_RESUME    = 8'hab;
	localparam logic [7:0] OP_RST_EN    = 8'h66;
	localparam logic [7:0] OP_RST_DO    = 8'h99;
	localparam logic [7:0] OP_TERMINATE = 8'hf0;
	localparam logic [7:0] OP_PG_BYTE   = 8'h02;
	localparam logic [7:0] OP_PG_SEQ_A  = 8'haf;
	localparam logic [7:0] OP_PG_SEQ_B  = 8'had;
	localparam logic [7:0] OP_PG_DUAL   = 8'ha2;
	localparam logic [7:0] OP_PG_QUAD   = 8'h32;
	localparam logic [7:0] OP_PG_OTP    = 8'h9b;
	localparam logic [7:0] OP_ER_4K     = 8'h20;
	localparam logic [7:0] OP_ER_32K    = 8'h52;
	localparam logic [7:0] OP_ER_64K    = 8'hd8;
	localparam logic [7:0] OP_ER_CHIP_A = 8'h60;
	localparam logic [7:0] OP_ER_CHIP_B = 8'hc7;

	// Select bit position inside the fourth status register
	localparam int SLEEP_SELECT_POS = 7;
	// Serial reset pattern of SI levels caught at four chip-select falls
	localparam logic [3:0] SER_RST_PATTERN = 4'h5;

	// Timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int LIGHT_SLEEP_EXIT_NS = 3000;
	localparam int DEEPEST_SLEEP_EXIT_NS = 300000;
	localparam int LIGHT_EXIT_CYC_I =
		(LIGHT_SLEEP_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DEEP_EXIT_CYC_I =
		(DEEPEST_SLEEP_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RCNT_W = 12;
	localparam logic [RCNT_W-1:0] LIGHT_EXIT_CYC = RCNT_W'(LIGHT_EXIT_CYC_I);
	localparam logic [RCNT_W-1:0] DEEP_EXIT_CYC = RCNT_W'(DEEP_EXIT_CYC_I);

	// Reset values
	localparam logic [1:0] SYNC_RST = 2'h3;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_LIGHT,
		ST_DEEP,
		ST_RECOVER
	} fpdrc_state_t;

	// Status shown to the rest of the device
	typedef struct packed {
		logic light_sleep;
		logic deepest_sleep;
		logic recovering;
		logic op_busy;
		logic prog_error;
		logic erase_error;
	} fpdrc_status_t;

	// Serial pins seen from the device
	typedef struct packed {
		logic sck;
		logic cs_n;
		logic si;
		logic reset_n;
	} fpdrc_pins_t;

endpackage

// *** logic/fpdrc_top.sv ***
// Power-down state control with reset and terminate handling for the flash
`timescale 1ns/10ps
module fpdrc_top (
	// Clock and reset
	input  wire logic                    i_clk,
	input  wire logic                    i_arst_n,
	// Serial pins from the host
	input  wire fpdrc_pkg::fpdrc_pins_t  i_pins,
	// Fourth status register and reset pin enable
	input  wire logic [7:0]              i_fourth_status_register,
	input  wire logic                    i_hw_reset_enable,
	// Program and erase engine
	input  wire logic                    i_op_done,
	input  wire logic                    i_prog_err_set,
	input  wire logic                    i_erase_err_set,
	// Serial output pin
	output logic                         o_so,
	output logic                         o_so_oe_n,
	// Status and events
	output fpdrc_pkg::fpdrc_status_t     o_status,
	output logic                         o_ready,
	output logic                         o_dev_reset,
	output logic                         o_op_halt
);
	import fpdrc_pkg::*;

	// Two-stage synchronisers for all pins
	logic [1:0] sck_s_reg, cs_s_reg, si_s_reg, rst_s_reg;
	logic       sck_d_reg, cs_d_reg, rst_d_reg;
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sck_s_reg <= 2'h0;
			cs_s_reg  <= SYNC_RST;
			si_s_reg  <= 2'h0;
			rst_s_reg <= SYNC_RST;
			sck_d_reg <= 1'b0;
			cs_d_reg  <= 1'b1;
			rst_d_reg <= 1'b1;
		end else begin
			sck_s_reg <= {sck_s_reg[0], i_pins.sck};
			cs_s_reg  <= {cs_s_reg[0], i_pins.cs_n};
			si_s_reg  <= {si_s_reg[0], i_pins.si};
			rst_s_reg <= {rst_s_reg[0], i_pins.reset_n};
			sck_d_reg <= sck_s_reg[1];
			cs_d_reg  <= cs_s_reg[1];
			rst_d_reg <= rst_s_reg[1];
		end
	end

	// Edge detection on the synchronised pins
	wire sck_rise = sck_s_reg[1] & ~sck_d_reg;
	wire cs_fall  = ~cs_s_reg[1] & cs_d_reg;
	wire cs_rise  = cs_s_reg[1] & ~cs_d_reg;
	wire sel_low  = ~cs_s_reg[1];
	wire pin_rst  = i_hw_reset_enable & ~rst_s_reg[1] & rst_d_reg;

	// Opcode shifter: first eight SCK rises of a frame
	logic [7:0] shift_reg;
	logic [3:0] bits_reg;
	logic       clocked_reg;
	logic [3:0] ser_hist_reg;
	logic       ser_si_reg;
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			shift_reg    <= 8'h00;
			bits_reg     <= 4'h0;
			clocked_reg  <= 1'b0;
			ser_hist_reg <= 4'h0;
			ser_si_reg   <= 1'b0;
		end else begin
			if (cs_fall) begin
				bits_reg    <= 4'h0;
				clocked_reg <= 1'b0;
				ser_si_reg  <= si_s_reg[1];
			end else if (sel_low && sck_rise) begin
				clocked_reg <= 1'b1;
				if (bits_reg < 4'h8) begin
					shift_reg <= {shift_reg[6:0], si_s_reg[1]};
					bits_reg  <= bits_reg + 4'h1;
				end
			end
			// Frames without clocks feed the serial reset history
			if (cs_rise)
				ser_hist_reg <= clocked_reg ? 4'h0
					: {ser_hist_reg[2:0], ser_si_reg};
		end
	end

	// Command decode at chip-select rise
	wire cmd_ok  = cs_rise & (bits_reg == 4'h8);
	wire ser_rst = cs_rise & ~clocked_reg
		& ({ser_hist_reg[2:0], ser_si_reg} == SER_RST_PATTERN);
	wire is_sleep  = cmd_ok & (shift_reg == OP_SLEEP);
	wire is_deep   = cmd_ok & (shift_reg == OP_DEEP);
	wire is_resume = cmd_ok & (shift_reg == OP_RESUME);
	wire is_rst_en = cmd_ok & (shift_reg == OP_RST_EN);
	wire is_rst_do = cmd_ok & (shift_reg == OP_RST_DO);
	wire is_term   = cmd_ok & (shift_reg == OP_TERMINATE);
	wire is_prog   = cmd_ok & ((shift_reg == OP_PG_BYTE)  // R16
		| (shift_reg == OP_PG_SEQ_A) | (shift_reg == OP_PG_SEQ_B)
		| (shift_reg == OP_PG_DUAL) | (shift_reg == OP_PG_QUAD)
		| (shift_reg == OP_PG_OTP));
	wire is_erase  = cmd_ok & ((shift_reg == OP_ER_4K)  // R17
		| (shift_reg == OP_ER_32K) | (shift_reg == OP_ER_64K)
		| (shift_reg == OP_ER_CHIP_A) | (shift_reg == OP_ER_CHIP_B));
	wire sel_light = i_fourth_status_register[SLEEP_SELECT_POS];  // R4

	// Main state and bookkeeping
	fpdrc_state_t      state_reg, state_next;
	logic [RCNT_W-1:0] rcnt_reg, rcnt_next;
	logic              arm_reg, busy_reg, busy_prog_reg;
	logic              perr_reg, eerr_reg;

	// External reset sources act from every state
	wire ext_rst  = ser_rst | pin_rst;  // R11 R14
	wire pair_rst = is_rst_do & arm_reg;
	wire in_light = (state_reg == ST_LIGHT);
	wire in_deep  = (state_reg == ST_DEEP);
	wire in_idle  = (state_reg == ST_IDLE);
	wire idle_rst = in_idle & pair_rst;  // R14
	wire lite_rst = in_light & pair_rst;  // R7
	wire deep_ab  = in_deep & is_resume;  // R6
	wire dev_rst  = ext_rst | idle_rst | lite_rst | deep_ab;
	wire halt     = in_idle & busy_reg & is_term;  // R15
	wire go_sleep = in_idle & ~busy_reg & (is_sleep | is_deep);

	// Next-state selection
	always_comb begin
		state_next = state_reg;
		rcnt_next  = (rcnt_reg != '0) ? rcnt_reg - 1'b1 : rcnt_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (go_sleep)
					state_next = (is_sleep & sel_light)  // R1 R2 R3
						? ST_LIGHT : ST_DEEP;
			end
			ST_LIGHT: begin
				// Resume, reset pair or external reset; F0h, CS ignored
				if (is_resume | lite_rst | ext_rst) begin  // R5 R9 R10
					state_next = ST_RECOVER;
					rcnt_next  = LIGHT_EXIT_CYC;  // R13
				end
			end
			ST_DEEP: begin
				// Only resume or external reset; pair and F0h ignored
				if (deep_ab | ext_rst) begin  // R8 R9 R10 R11
					state_next = ST_RECOVER;
					rcnt_next  = DEEP_EXIT_CYC;  // R13
				end
			end
			ST_RECOVER: begin
				if (rcnt_reg == '0)
					state_next = ST_IDLE;
			end
		endcase
	end

	// State, counter and reset-enable latch
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_reg <= ST_IDLE;
			rcnt_reg  <= '0;
			arm_reg   <= 1'b0;
		end else begin
			state_reg <= state_next;
			rcnt_reg  <= rcnt_next;
			if (dev_rst)
				arm_reg <= 1'b0;
			else if (cmd_ok)
				arm_reg <= is_rst_en;  // R7
		end
	end

	// Program/erase tracking and volatile error flags; flag sets win over clears, busy clears win
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			busy_reg      <= 1'b0;
			busy_prog_reg <= 1'b0;
			perr_reg      <= 1'b0;
			eerr_reg      <= 1'b0;
		end else begin
			if (dev_rst | halt | i_op_done)  // R14 R15
				busy_reg <= 1'b0;
			else if (in_idle & ~busy_reg & (is_prog | is_erase))
				busy_reg <= 1'b1;
			if (in_idle & ~busy_reg & (is_prog | is_erase))
				busy_prog_reg <= is_prog;
			// Light wake leaves flags alone, any reset clears them
			if (i_prog_err_set | (halt & busy_prog_reg))
				perr_reg <= 1'b1;
			else if (dev_rst | (in_idle & ~busy_reg & is_prog))  // R18
				perr_reg <= 1'b0;
			if (i_erase_err_set | (halt & ~busy_prog_reg))
				eerr_reg <= 1'b1;
			else if (dev_rst | (in_idle & ~busy_reg & is_erase))  // R18
				eerr_reg <= 1'b0;
		end
	end

	// Registered outputs; serial output is never driven by this block
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_so        <= 1'b0;
			o_so_oe_n   <= 1'b1;
			o_status    <= '0;
			o_ready     <= 1'b0;
			o_dev_reset <= 1'b0;
			o_op_halt   <= 1'b0;
		end else begin
			o_so                   <= 1'b0;
			o_so_oe_n              <= 1'b1;  // R19
			o_status.light_sleep   <= (state_next == ST_LIGHT);
			o_status.deepest_sleep <= (state_next == ST_DEEP);
			o_status.recovering    <= (state_next == ST_RECOVER);
			o_status.op_busy       <= busy_reg;
			o_status.prog_error    <= perr_reg;
			o_status.erase_error   <= eerr_reg;
			o_ready                <= (state_next == ST_IDLE);
			o_dev_reset            <= dev_rst;
			o_op_halt              <= halt;
		end
	end

endmodule
